// ### hdl/fce_pkg.sv
// constants and types shared by the flash command engine
package fce_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [4:0] OFS_STATUS = 5'h00;
   localparam logic [4:0] OFS_CMD0 = 5'h04;
   localparam logic [4:0] OFS_CMD1 = 5'h08;
   localparam logic [4:0] OFS_CMD2 = 5'h0c;
   localparam logic [4:0] OFS_PROT = 5'h10;
   localparam logic [4:0] OFS_CTRL = 5'h14;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int BIT_CC = 7;
   localparam int BIT_ACC = 5;
   localparam int BIT_PV = 4;
   localparam int BIT_FAIL = 0;
   localparam int BIT_SPECIAL = 0;
   localparam int BIT_SECURE = 1;
   localparam logic RST_CC = 1'b1;
   localparam logic [31:0] RST_PROT = 32'h0000_0000;

   // ------------------------------------------------------------
   // command codes and parameter codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_ERASED_SECTION_CHECK = 8'h01;
   localparam logic [7:0] CMD_PROGRAMMED_LONGWORD_CHECK = 8'h02;
   localparam logic [7:0] CMD_SPECIAL_RESOURCE_READ = 8'h03;
   localparam logic [7:0] CMD_LONGWORD_PROGRAM = 8'h06;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h09;
   localparam logic [7:0] SEL_NORMAL = 8'h00;
   localparam logic [7:0] SEL_USER = 8'h01;
   localparam logic [7:0] SEL_FACTORY = 8'h02;
   localparam logic [7:0] RES_INFORMATION_ROW = 8'h00;
   localparam logic [7:0] RES_VERSION_ID = 8'h01;
   localparam logic [23:0] RES_INFO_LAST = 24'h00_00ff;
   localparam logic [23:0] RES_VER_LAST = 24'h00_0007;

   // ------------------------------------------------------------
   // array port encodings
   // ------------------------------------------------------------
   localparam logic [2:0] MRG_NORMAL = 3'h0;
   localparam logic [2:0] MRG_USER1 = 3'h1;
   localparam logic [2:0] MRG_FACTORY1 = 3'h2;
   localparam logic [2:0] MRG_USER0 = 3'h3;
   localparam logic [2:0] MRG_FACTORY0 = 3'h4;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_PROGRAM = 2'h1;
   localparam logic [1:0] OP_ERASE = 2'h2;
   localparam logic [1:0] SPC_MAIN = 2'h0;
   localparam logic [1:0] SPC_INFO = 2'h1;
   localparam logic [1:0] SPC_VERSION = 2'h2;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int DEF_FLASH_BYTES = 65536;
   localparam int DEF_SECTOR_BYTES = 1024;

   typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_ARRAY} fce_state_t;

endpackage

// ### hdl/fce_engine.sv
// flash command engine: avalon register slave, parameter checks and array sequencing
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module fce_engine
   import fce_pkg::*;
#(
   parameter int FLASH_BYTES = fce_pkg::DEF_FLASH_BYTES,
   parameter int SECTOR_BYTES = fce_pkg::DEF_SECTOR_BYTES
)
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic arr_req_out,
   output logic [1:0] arr_op_out,
   output logic [2:0] arr_margin_out,
   output logic [1:0] arr_space_out,
   output logic [23:0] arr_addr_out,
   output logic [31:0] arr_wdata_out,
   input wire logic arr_ack_in,
   input wire logic [31:0] arr_rdata_in,
   output logic busy_out
);
   import fce_pkg::*;

   localparam logic [25:0] FLASH_LIM = 26'(FLASH_BYTES);
   localparam logic [23:0] SECTOR_MASK = 24'(SECTOR_BYTES - 1);
   localparam logic [15:0] SECTOR_WORDS = 16'(SECTOR_BYTES / 4);
   localparam int REGION_SHIFT = $clog2(FLASH_BYTES) - 5;

   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic cc;
      logic acc;
      logic pv;
      logic fail;
      logic [11:0][7:0] cmd;
      logic [31:0] prot;
      logic special;
      logic secure;
      fce_state_t state;
      logic [23:0] addr;
      logic [15:0] cnt;
      logic pass;
      logic req;
      logic [1:0] op;
      logic [2:0] margin;
      logic [1:0] space;
      logic [31:0] wdata;
      logic busy;
   } fce_regs_t;

   fce_regs_t s_ff;
   fce_regs_t nxt_s;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic addr_bad(input logic [23:0] a);
      addr_bad = ({2'b00, a} >= FLASH_LIM) || (a[1:0] != 2'b00);
   endfunction

   function automatic logic is_protected(input logic [31:0] prot, input logic [23:0] a);
      logic [23:0] region;
      region = a >> REGION_SHIFT;
      is_protected = prot[region[4:0]];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      merge = r;
   endfunction

   logic [31:0] cmd_w0;
   logic [31:0] cmd_w1;
   logic [31:0] cmd_w2;
   logic [23:0] cmd_addr;
   logic [15:0] cmd_count;
   logic unavail;
   logic chk_acc;
   logic chk_pv;

   assign cmd_w0 = {s_ff.cmd[0], s_ff.cmd[1], s_ff.cmd[2], s_ff.cmd[3]};
   assign cmd_w1 = {s_ff.cmd[4], s_ff.cmd[5], s_ff.cmd[6], s_ff.cmd[7]};
   assign cmd_w2 = {s_ff.cmd[8], s_ff.cmd[9], s_ff.cmd[10], s_ff.cmd[11]};
   assign cmd_addr = cmd_w0[23:0];
   assign cmd_count = {s_ff.cmd[4], s_ff.cmd[5]};
   assign unavail = s_ff.special && s_ff.secure;

   // ------------------------------------------------------------
   // parameter and protection checks
   // ------------------------------------------------------------
   always_comb
   begin
      chk_acc = 1'b0;
      chk_pv = 1'b0;
      unique case (s_ff.cmd[0])
         CMD_ERASED_SECTION_CHECK:
         begin
            chk_acc = unavail || (s_ff.cmd[6] > SEL_FACTORY) || addr_bad(cmd_addr)
                      || (cmd_count == 16'h0000)
                      || (({2'b00, cmd_addr} + {8'h00, cmd_count, 2'b00}) > FLASH_LIM);
         end
         CMD_PROGRAMMED_LONGWORD_CHECK:
         begin
            chk_acc = unavail || addr_bad(cmd_addr)
                      || !((s_ff.cmd[4] == SEL_USER) || (s_ff.cmd[4] == SEL_FACTORY));
         end
         CMD_SPECIAL_RESOURCE_READ:
         begin
            chk_acc = unavail || (cmd_addr[1:0] != 2'b00)
                      || ((s_ff.cmd[8] == RES_INFORMATION_ROW) && (cmd_addr > RES_INFO_LAST))
                      || ((s_ff.cmd[8] == RES_VERSION_ID) && (cmd_addr > RES_VER_LAST))
                      || (s_ff.cmd[8] > RES_VERSION_ID);
         end
         CMD_LONGWORD_PROGRAM, CMD_SECTOR_ERASE:
         begin
            chk_acc = unavail || addr_bad(cmd_addr);
            chk_pv = is_protected(s_ff.prot, cmd_addr);
         end
         default:
         begin
            chk_acc = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_s = s_ff;
      // one wait cycle per access, then the answer stands for one cycle
      if (s_ff.waitreq)
      begin
         if (avs_read_in || avs_write_in)
         begin
            nxt_s.waitreq = 1'b0;
            unique case (avs_address_in)
               OFS_STATUS: nxt_s.rdata = 32'(({s_ff.cc, 1'b0, s_ff.acc, s_ff.pv, 3'h0, s_ff.fail}));
               OFS_CMD0: nxt_s.rdata = cmd_w0;
               OFS_CMD1: nxt_s.rdata = cmd_w1;
               OFS_CMD2: nxt_s.rdata = cmd_w2;
               OFS_PROT: nxt_s.rdata = s_ff.prot;
               OFS_CTRL: nxt_s.rdata = {30'h0, s_ff.secure, s_ff.special};
               default: nxt_s.rdata = 32'h0000_0000;
            endcase
         end
      end
      else
      begin
         nxt_s.waitreq = 1'b1;
      end

      // writes land only while idle, so they never race the engine's flag sets
      if (avs_write_in && !s_ff.waitreq && s_ff.cc)
      begin
         unique case (avs_address_in)
            OFS_STATUS:
            begin
               if (avs_byteenable_in[0])
               begin
                  if (avs_writedata_in[BIT_ACC])
                  begin
                     nxt_s.acc = 1'b0;
                  end
                  if (avs_writedata_in[BIT_PV])
                  begin
                     nxt_s.pv = 1'b0;
                  end
                  // old flags decide, so clearing errors and launching needs two writes
                  if (avs_writedata_in[BIT_CC] && !s_ff.acc && !s_ff.pv)
                  begin
                     nxt_s.cc = 1'b0;
                     nxt_s.fail = 1'b0;
                     nxt_s.state = ST_CHECK;
                  end
               end
            end
            OFS_CMD0: {nxt_s.cmd[0], nxt_s.cmd[1], nxt_s.cmd[2], nxt_s.cmd[3]}
                         = merge(cmd_w0, avs_writedata_in, avs_byteenable_in);
            OFS_CMD1: {nxt_s.cmd[4], nxt_s.cmd[5], nxt_s.cmd[6], nxt_s.cmd[7]}
                         = merge(cmd_w1, avs_writedata_in, avs_byteenable_in);
            OFS_CMD2: {nxt_s.cmd[8], nxt_s.cmd[9], nxt_s.cmd[10], nxt_s.cmd[11]}
                         = merge(cmd_w2, avs_writedata_in, avs_byteenable_in);
            OFS_PROT: nxt_s.prot = merge(s_ff.prot, avs_writedata_in, avs_byteenable_in);
            OFS_CTRL:
            begin
               if (avs_byteenable_in[0])
               begin
                  nxt_s.special = avs_writedata_in[BIT_SPECIAL];
                  nxt_s.secure = avs_writedata_in[BIT_SECURE];
               end
            end
            default:
            begin
            end
         endcase
      end

      unique case (s_ff.state)
         ST_IDLE:
         begin
         end
         ST_CHECK:
         begin
            nxt_s.pass = 1'b0;
            nxt_s.addr = cmd_addr;
            nxt_s.cnt = cmd_count;
            nxt_s.op = OP_READ;
            nxt_s.space = SPC_MAIN;
            nxt_s.margin = MRG_NORMAL;
            nxt_s.wdata = cmd_w1;
            if (chk_acc || chk_pv)
            begin
               nxt_s.acc = chk_acc;
               nxt_s.pv = chk_pv && !chk_acc;
               nxt_s.cc = 1'b1;
               nxt_s.state = ST_IDLE;
            end
            else
            begin
               nxt_s.req = 1'b1;
               nxt_s.state = ST_ARRAY;
               unique case (s_ff.cmd[0])
                  CMD_ERASED_SECTION_CHECK: nxt_s.margin = s_ff.cmd[6][2:0];
                  CMD_PROGRAMMED_LONGWORD_CHECK:
                     nxt_s.margin = (s_ff.cmd[4] == SEL_USER) ? MRG_USER1 : MRG_FACTORY1;
                  CMD_SPECIAL_RESOURCE_READ:
                     nxt_s.space = (s_ff.cmd[8] == RES_VERSION_ID) ? SPC_VERSION : SPC_INFO;
                  CMD_LONGWORD_PROGRAM: nxt_s.op = OP_PROGRAM;
                  default:
                  begin
                     nxt_s.op = OP_ERASE;
                     nxt_s.addr = cmd_addr & ~SECTOR_MASK;
                     nxt_s.cnt = SECTOR_WORDS;
                  end
               endcase
            end
         end
         ST_ARRAY:
         begin
            if (arr_ack_in)
            begin
               nxt_s.req = 1'b0;
               nxt_s.cc = 1'b1;
               nxt_s.state = ST_IDLE;
               unique case (s_ff.cmd[0])
                  CMD_PROGRAMMED_LONGWORD_CHECK:
                  begin
                     if (arr_rdata_in != cmd_w2)
                     begin
                        nxt_s.fail = 1'b1;
                     end
                     if (!s_ff.pass)
                     begin
                        nxt_s.pass = 1'b1;
                        nxt_s.margin = (s_ff.margin == MRG_USER1) ? MRG_USER0 : MRG_FACTORY0;
                        nxt_s.req = 1'b1;
                        nxt_s.cc = 1'b0;
                        nxt_s.state = ST_ARRAY;
                     end
                  end
                  CMD_SPECIAL_RESOURCE_READ:
                  begin
                     {nxt_s.cmd[4], nxt_s.cmd[5], nxt_s.cmd[6], nxt_s.cmd[7]} = arr_rdata_in;
                  end
                  CMD_LONGWORD_PROGRAM:
                  begin
                     if (s_ff.pass && ((~s_ff.wdata & arr_rdata_in) != 32'h0000_0000))
                     begin
                        nxt_s.fail = 1'b1;
                     end
                     if (!s_ff.pass)
                     begin
                        nxt_s.pass = 1'b1;
                        nxt_s.op = OP_READ;
                        nxt_s.req = 1'b1;
                        nxt_s.cc = 1'b0;
                        nxt_s.state = ST_ARRAY;
                     end
                  end
                  default:
                  begin
                     // section check, and the verify sweep after a sector erase
                     if (s_ff.op == OP_ERASE)
                     begin
                        nxt_s.op = OP_READ;
                        nxt_s.req = 1'b1;
                        nxt_s.cc = 1'b0;
                        nxt_s.state = ST_ARRAY;
                     end
                     else
                     begin
                        if (arr_rdata_in != 32'hffff_ffff)
                        begin
                           nxt_s.fail = 1'b1;
                        end
                        if (s_ff.cnt != 16'h0001)
                        begin
                           nxt_s.addr = s_ff.addr + 24'h00_0004;
                           nxt_s.cnt = s_ff.cnt - 16'h0001;
                           nxt_s.req = 1'b1;
                           nxt_s.cc = 1'b0;
                           nxt_s.state = ST_ARRAY;
                        end
                     end
                  end
               endcase
            end
         end
      endcase
      // kept as its own flop so the port needs no inverter
      nxt_s.busy = !nxt_s.cc;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         s_ff <= '0;
         s_ff.waitreq <= 1'b1;
         s_ff.cc <= RST_CC;
         s_ff.prot <= RST_PROT;
         s_ff.state <= ST_IDLE;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign avs_readdata_out = s_ff.rdata;
   assign avs_waitrequest_out = s_ff.waitreq;
   assign arr_req_out = s_ff.req;
   assign arr_op_out = s_ff.op;
   assign arr_margin_out = s_ff.margin;
   assign arr_space_out = s_ff.space;
   assign arr_addr_out = s_ff.addr;
   assign arr_wdata_out = s_ff.wdata;
   assign busy_out = s_ff.busy;

endmodule

`default_nettype wire

// ### dv/fce_engine_properties.sv
// concurrent checks on the flash command engine ports
`timescale 1ns/1ps
`default_nettype none
module fce_engine_chk
   import fce_pkg::*;
#(
   parameter int FLASH_BYTES = 4096,
   parameter int SECTOR_BYTES = 256
)
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_write_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic avs_waitrequest_out,
   input wire logic arr_req_out,
   input wire logic [1:0] arr_op_out,
   input wire logic [2:0] arr_margin_out,
   input wire logic [1:0] arr_space_out,
   input wire logic [23:0] arr_addr_out,
   input wire logic arr_ack_in,
   input wire logic busy_out
);
   logic u1_done_ff;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         u1_done_ff <= 1'b0;
      else
         u1_done_ff <= arr_ack_in && arr_margin_out == MRG_USER1;
   end
   sequence s_user0_start;
      arr_req_out && arr_margin_out == MRG_USER0 && $changed(arr_margin_out);
   endsequence
   a_launch_cause: assert property ($rose(busy_out) |-> $past(avs_write_in && !avs_waitrequest_out
      && avs_address_in == OFS_STATUS && avs_writedata_in[BIT_CC] && avs_byteenable_in[0]))
      else $error("command started without a launch write");
   a_req_in_cmd: assert property (arr_req_out |-> busy_out)
      else $error("array request outside a command");
   a_req_holds: assert property (arr_req_out && !arr_ack_in |=> arr_req_out && $stable(arr_addr_out))
      else $error("array request dropped before acknowledge");
   a_addr_aligned: assert property (arr_req_out && arr_space_out == SPC_MAIN |-> arr_addr_out[1:0] == 2'h0)
      else $error("misaligned array address");
   a_main_range: assert property (arr_req_out && arr_space_out == SPC_MAIN |-> arr_addr_out < FLASH_BYTES)
      else $error("array address beyond flash");
   a_res_range: assert property (arr_req_out && arr_space_out != SPC_MAIN |-> arr_addr_out <=
      ((arr_space_out == SPC_INFO) ? RES_INFO_LAST : RES_VER_LAST))
      else $error("resource address out of range");
   a_read0_after: assert property (s_user0_start |-> u1_done_ff)
      else $error("read-0 pass without read-1 pass");
   a_erase_base: assert property (arr_req_out && arr_op_out == OP_ERASE |-> arr_addr_out % SECTOR_BYTES == 0)
      else $error("erase not at sector base");
endmodule
bind fce_engine fce_engine_chk #(.FLASH_BYTES(FLASH_BYTES), .SECTOR_BYTES(SECTOR_BYTES)) u_chk (
   .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
   .avs_byteenable_in(avs_byteenable_in), .avs_writedata_in(avs_writedata_in),
   .avs_waitrequest_out(avs_waitrequest_out), .arr_req_out(arr_req_out), .arr_op_out(arr_op_out),
   .arr_margin_out(arr_margin_out), .arr_space_out(arr_space_out), .arr_addr_out(arr_addr_out),
   .arr_ack_in(arr_ack_in), .busy_out(busy_out));
`default_nettype wire

// ### dv/fce_array_model.sv
// behavioural flash array behind the engine's array port
`timescale 1ns/1ps
`default_nettype none
module fce_array_model
   import fce_pkg::*;
#(
   parameter int FLASH_BYTES = 4096,
   parameter int SECTOR_BYTES = 256
)
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic req_in,
   input wire logic [1:0] op_in,
   input wire logic [1:0] space_in,
   input wire logic [23:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [31:0] stuck_in,
   output logic ack_out,
   output logic [31:0] rdata_out
);
   logic [31:0] mem [FLASH_BYTES/4];
   int cnt;
   int w;
   initial
   begin
      for (int i = 0; i < FLASH_BYTES/4; i++)
         mem[i] = 32'hffff_ffff;
   end
   // odd longwords answer slowly so the engine must wait
   always @(posedge clk_in or negedge nrst_in)
   begin
      w = addr_in / 4;
      if (!nrst_in)
      begin
         ack_out <= 1'b0;
         cnt <= 0;
         rdata_out <= 32'h0;
      end
      else if (ack_out)
      begin
         ack_out <= 1'b0;
         cnt <= 0;
         // stale data must never look valid
         rdata_out <= ~rdata_out;
      end
      else if (req_in && cnt < 3 * addr_in[2])
         cnt <= cnt + 1;
      else if (req_in)
      begin
         ack_out <= 1'b1;
         if (op_in == OP_PROGRAM)
            mem[w] = (mem[w] & wdata_in) | stuck_in;
         if (op_in == OP_ERASE)
            for (int i = 0; i < SECTOR_BYTES/4; i++)
               mem[w + i] = 32'hffff_ffff;
         for (int i = 0; i < 4; i++)
            rdata_out[8*i +: 8] <= (space_in == SPC_INFO) ? (addr_in[7:0] + i[7:0]) ^ 8'h5a
               : 8'hc0 + addr_in[7:0] + i[7:0];
         if (space_in == SPC_MAIN)
            rdata_out <= mem[w];
      end
   end
endmodule
`default_nettype wire

// ### dv/fce_engine_tb.sv
// self-checking bench for the flash command engine
`timescale 1ns/1ps
`default_nettype none
module fce_engine_tb;
   import fce_pkg::*;
   logic clk_in;
   logic nrst_in;
   logic [4:0] avs_address_in;
   logic avs_read_in;
   logic avs_write_in;
   logic [3:0] avs_byteenable_in;
   logic [31:0] avs_writedata_in;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic arr_req_out;
   logic [1:0] arr_op_out;
   logic [2:0] arr_margin_out;
   logic [1:0] arr_space_out;
   logic [23:0] arr_addr_out;
   logic [31:0] arr_wdata_out;
   logic arr_ack_in;
   logic [31:0] arr_rdata_in;
   logic busy_out;
   logic [31:0] stuck;
   logic [31:0] st;
   logic [2:0] seen_margin;
   int n_mismatch;
   int n_tests;
   fce_engine #(.FLASH_BYTES(4096), .SECTOR_BYTES(256)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .arr_req_out(arr_req_out), .arr_op_out(arr_op_out), .arr_margin_out(arr_margin_out),
      .arr_space_out(arr_space_out), .arr_addr_out(arr_addr_out), .arr_wdata_out(arr_wdata_out),
      .arr_ack_in(arr_ack_in), .arr_rdata_in(arr_rdata_in), .busy_out(busy_out));
   fce_array_model u_arr (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(arr_req_out),
      .op_in(arr_op_out), .space_in(arr_space_out), .addr_in(arr_addr_out),
      .wdata_in(arr_wdata_out), .stuck_in(stuck), .ack_out(arr_ack_in), .rdata_out(arr_rdata_in));
   // margin of the last finished array operation
   always @(posedge clk_in)
   begin
      if (arr_ack_in)
         seen_margin <= arr_margin_out;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'b0)
         @(posedge clk_in);
      st = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic load(input logic [31:0] c0, input logic [31:0] c1, input logic [31:0] c2);
      bus(1'b1, OFS_CMD0, c0);
      bus(1'b1, OFS_CMD1, c1);
      bus(1'b1, OFS_CMD2, c2);
   endtask
   // busy rises on the same edge that accepts the launch write
   task automatic launch();
      bus(1'b1, OFS_STATUS, 32'h80);
      repeat (2) @(posedge clk_in);
      while (busy_out !== 1'b0)
         @(posedge clk_in);
      bus(1'b0, OFS_STATUS, 32'h0);
   endtask
   task automatic run(input logic [31:0] c0, c1, c2, input logic [7:0] exp);
      load(c0, c1, c2);
      launch();
      check(st, {24'h0, exp});
      bus(1'b1, OFS_STATUS, 32'h30);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      bus(1'b0, OFS_STATUS, 32'h0);
      check(st, {24'h0, RST_CC, 7'h0});
      bus(1'b0, OFS_PROT, 32'h0);
      check(st, RST_PROT);
      bus(1'b0, 5'h18, 32'h0);
      check(st, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_program();
      run(32'h0600_0100, 32'h1234_5678, 32'h0, 8'h80);
      check(u_arr.mem[64], 32'h1234_5678);
      stuck <= 32'h1;
      run(32'h0600_0104, 32'hffff_fffe, 32'h0, 8'h81);
      stuck <= 32'h0;
      run(32'h0600_0102, 32'h0, 32'h0, 8'ha0);
      run(32'h0600_1000, 32'h0, 32'h0, 8'ha0);
      $display("test program done");
   endtask
   task automatic t_check();
      run(32'h0200_0100, 32'h0100_0000, 32'h1234_5678, 8'h80);
      check(32'(seen_margin), 32'(MRG_USER0));
      run(32'h0200_0100, 32'h0200_0000, 32'h1234_5678, 8'h80);
      check(32'(seen_margin), 32'(MRG_FACTORY0));
      run(32'h0200_0100, 32'h0100_0000, 32'h1234_5679, 8'h81);
      run(32'h0200_0100, 32'h0000_0000, 32'h1234_5678, 8'ha0);
      run(32'h0200_0100, 32'h0300_0000, 32'h1234_5678, 8'ha0);
      run(32'h0200_1000, 32'h0100_0000, 32'h1234_5678, 8'ha0);
      $display("test check done");
   endtask
   task automatic t_section();
      for (int m = 0; m < 3; m++)
      begin
         run(32'h0100_0200, {16'h4, m[7:0], 8'h0}, 32'h0, 8'h80);
         check(32'(seen_margin),
               (m == 0) ? 32'(MRG_NORMAL) : (m == 1) ? 32'(MRG_USER1) : 32'(MRG_FACTORY1));
      end
      run(32'h0100_00fc, 32'h0002_0000, 32'h0, 8'h81);
      run(32'h0100_0200, 32'h0004_0300, 32'h0, 8'ha0);
      run(32'h0100_0200, 32'h0000_0000, 32'h0, 8'ha0);
      run(32'h0100_0ff0, 32'h0008_0000, 32'h0, 8'ha0);
      run(32'h0100_0201, 32'h0001_0000, 32'h0, 8'ha0);
      $display("test section done");
   endtask
   task automatic t_resource();
      run(32'h0300_0010, 32'h0, 32'h0000_0000, 8'h80);
      bus(1'b0, OFS_CMD1, 32'h0);
      check(st, 32'h4948_4b4a);
      run(32'h0300_0004, 32'h0, 32'h0100_0000, 8'h80);
      bus(1'b0, OFS_CMD1, 32'h0);
      check(st, 32'hc7c6_c5c4);
      run(32'h0300_0010, 32'h0, 32'h0200_0000, 8'ha0);
      run(32'h0300_0100, 32'h0, 32'h0000_0000, 8'ha0);
      run(32'h0300_0008, 32'h0, 32'h0100_0000, 8'ha0);
      run(32'h0300_0012, 32'h0, 32'h0000_0000, 8'ha0);
      $display("test resource done");
   endtask
   task automatic t_protect();
      bus(1'b1, OFS_PROT, 32'h4);
      load(32'h0600_0100, 32'h0, 32'h0);
      launch();
      check(st, 32'h90);
      load(32'h0300_0010, 32'h0, 32'h0);
      launch();
      check(st, 32'h90);
      bus(1'b0, OFS_CMD1, 32'h0);
      check(st, 32'h0);
      bus(1'b1, OFS_STATUS, 32'h30);
      launch();
      check(st, 32'h80);
      run(32'h0600_0102, 32'h0, 32'h0, 8'ha0);
      bus(1'b1, OFS_PROT, 32'h0);
      $display("test protect done");
   endtask
   task automatic t_mode();
      logic [7:0] codes [6] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h09, 8'h07};
      bus(1'b1, OFS_CTRL, 32'h3);
      foreach (codes[i])
         run({codes[i], 24'h000200}, 32'h0001_0000, 32'h0, 8'ha0);
      bus(1'b1, OFS_CTRL, 32'h0);
      run(32'h0700_0200, 32'h0, 32'h0, 8'ha0);
      $display("test mode done");
   endtask
   task automatic t_erase();
      run(32'h0900_01ac, 32'h0, 32'h0, 8'h80);
      run(32'h0100_0100, 32'h0040_0000, 32'h0, 8'h80);
      check(u_arr.mem[64], 32'hffff_ffff);
      $display("test erase done");
   endtask
   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial
   begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      conclude();
   end
   initial
   begin
      nrst_in = 1'b0;
      avs_address_in = 5'h0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_byteenable_in = 4'hf;
      avs_writedata_in = 32'h0;
      stuck = 32'h0;
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset();
      t_program();
      t_check();
      t_section();
      t_resource();
      t_protect();
      t_mode();
      t_erase();
      conclude();
   end
endmodule
`default_nettype wire
